// >>> ssq_checker.sv
// Port checker for the acquisition host controller.
`timescale 1ns/100ps
module ssq_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Status and results
    input wire logic busy,
    input wire logic armed,
    input wire logic done,
    input wire logic overflow_seen,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic [15:0] res_data,
    // Device side
    input wire logic [7:0] dev_addr,
    input wire logic dev_wr,
    input wire logic dev_rd,
    input wire logic [15:0] dev_data_out,
    input wire logic dev_data_oe,
    input wire logic external_start_trigger_n
);
    logic [5:0] low_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Counts the cycles for which the trigger pin has been held low.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= 6'h00;
        end else begin
            low_q <= external_start_trigger_n ? 6'h00 : low_q + 6'h01;
        end
    end
    // ==================================================
    // Properties
    property p_wr_len; $rose(dev_wr) |-> dev_wr [*6] ##1 !dev_wr; endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe length wrong");
    property p_rd_len; $rose(dev_rd) |-> dev_rd [*6] ##1 !dev_rd; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
    property p_excl; !(dev_wr && dev_rd) && (dev_data_oe == dev_wr); endproperty
    a_excl: assert property (p_excl) else $error("strobes or drive enable clash");
    property p_hold; dev_wr && $past(dev_wr) |-> $stable(dev_addr) && $stable(dev_data_out); endproperty
    a_hold: assert property (p_hold) else $error("write word moved mid strobe");
    property p_trig; $rose(external_start_trigger_n) |-> low_q == 6'h14; endproperty
    a_trig: assert property (p_trig) else $error("trigger pulse width wrong");
    property p_trig_busy; !external_start_trigger_n |-> busy; endproperty
    a_trig_busy: assert property (p_trig_busy) else $error("trigger outside a run");
    property p_res_hold; res_valid && !res_ready |=> res_valid && $stable(res_data); endproperty
    a_res_hold: assert property (p_res_hold) else $error("result dropped while stalled");
    property p_done; done |-> armed && !busy; endproperty
    a_done: assert property (p_done) else $error("finished state not rearmed");
    property p_halt; overflow_seen && !busy |-> !armed; endproperty
    a_halt: assert property (p_halt) else $error("still armed after overflow");
    property p_wr_busy; dev_wr |-> busy; endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("device write while idle");
    // Main scenarios reached.
    c_trig: cover property ($fell(external_start_trigger_n));
    c_done: cover property ($rose(done));
    c_ovf: cover property ($rose(overflow_seen));
endmodule
bind ssq_sequencer ssq_checker u_chk (.*);

// >>> ssq_dev_model.sv
// Behavioural model of the acquisition board behind the register interface.
`timescale 1ns/100ps
module ssq_dev_model
    import ssq_pkg::*;
#(
    parameter int ENTRIES = 3,
    parameter int PACE = 40
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Register interface
    input wire logic [7:0] dev_addr,
    input wire logic dev_wr,
    input wire logic dev_rd,
    input wire logic [15:0] dev_data_out,
    output logic [15:0] dev_data_in,
    // Trigger pin and bench controls
    input wire logic external_start_trigger_n,
    input wire logic [16:0] sample_count,
    input wire logic ovr_req
);
    logic [15:0] fifo_q[$];
    logic [15:0] rdat_q = 16'h0000;
    logic ovf_q, ovr_q, arm_q, run_q, wr_q, rd_q, trg_q, go;
    int ptr_q, seq_q, left_q, pace_q;
    // A released bus shows the inverse of the last word.
    assign dev_data_in = dev_rd ? rdat_q : ~rdat_q;
    // Register decode, conversion pacing and error detection.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_q.delete();
            {ovf_q, ovr_q, arm_q, run_q, wr_q, rd_q, trg_q} = 7'h01;
            {ptr_q, seq_q, left_q, pace_q} = 128'h0;
        end else begin
            go = !external_start_trigger_n && trg_q;
            if (dev_wr && !wr_q) begin
                case (dev_addr)
                    A_CMD1: arm_q = dev_data_out[B_ACQ_EN] & dev_data_out[B_SCAN_EN];
                    A_CONV_CLEAR: begin
                        fifo_q.delete();
                        {ovf_q, ovr_q} = 2'h0;
                    end
                    A_SCAN_PTR: ptr_q = 0;
                    A_START: go = 1'b1;
                    default: ;
                endcase
            end
            if (go && arm_q) begin
                run_q = 1'b1;
                left_q = sample_count;
                pace_q = PACE;
            end else if (run_q && pace_q == 0) begin
                if (ovr_req) begin
                    {ovr_q, run_q} = 2'h2;
                end else if (fifo_q.size() == 16) begin
                    {ovf_q, run_q} = 2'h2;
                end else begin
                    fifo_q.push_back({4'(ptr_q), 12'(seq_q)});
                    ptr_q = (ptr_q + 1) % ENTRIES;
                    seq_q++;
                    left_q--;
                    run_q = left_q != 0;
                    pace_q = PACE;
                end
            end else if (run_q) begin
                pace_q--;
            end
            if (dev_rd && !rd_q) begin
                rdat_q = dev_addr == A_RESULT ? fifo_q.pop_front() : {13'h0000, ovr_q, ovf_q, fifo_q.size() != 0};
            end
            {wr_q, rd_q, trg_q} = {dev_wr, dev_rd, external_start_trigger_n};
        end
    end
endmodule

// >>> ssq_pkg.sv
// Constants shared by the scanned acquisition sequencer host controller.
package ssq_pkg;
    // ==================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned STROBE_NS = 60;
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned TRIG_PULSE_NS = 200;
    localparam int unsigned TRIG_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned GUARD_NS = 2000;
    localparam int unsigned MAX_RATE_SPS = 23800;
    localparam int unsigned TB1M_HZ = 1000000;
    localparam logic [16:0] MIN_SAMPLE_TB1M = 17'((TB1M_HZ + MAX_RATE_SPS - 1) / MAX_RATE_SPS);
    localparam logic [22:0] GUARD_TB1M = 23'((GUARD_NS + 999) / 1000);
    localparam logic [22:0] GUARD_SLOW = 23'h000001;
    // ==================================================
    // Device register addresses
    localparam logic [7:0] A_CMD1 = 8'h00;
    localparam logic [7:0] A_CMD2 = 8'h02;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_RESULT = 8'h06;
    localparam logic [7:0] A_CONV_CLEAR = 8'h08;
    localparam logic [7:0] A_SCAN_PTR = 8'h0A;
    localparam logic [7:0] A_START = 8'h0C;
    localparam logic [7:0] A_TMR_EDGE_CLR = 8'h0E;
    localparam logic [7:0] A_CTR_DATA = 8'h10;
    localparam logic [7:0] A_CTR_CMD = 8'h12;
    // ==================================================
    // Field positions
    localparam int unsigned B_ACQ_EN = 0;
    localparam int unsigned B_SCAN_EN = 1;
    localparam int unsigned B_SCAN2_EN = 0;
    localparam int unsigned B_AVAIL = 0;
    localparam int unsigned B_OVERFLOW = 1;
    localparam int unsigned B_OVERRUN = 2;
    // ==================================================
    // Counter chip commands and values, then interval limits, last step numbers and FIFO sizes
    localparam logic [15:0] C_SEL_MODE2 = 16'hFF02;
    localparam logic [15:0] C_SEL_LOAD2 = 16'hFF0A;
    localparam logic [15:0] C_LOAD2 = 16'hFF42;
    localparam logic [15:0] C_STEP2 = 16'hFFF2;
    localparam logic [15:0] C_ARM2 = 16'hFF22;
    localparam logic [15:0] C_DISARM2 = 16'hFFC2;
    localparam logic [15:0] C_DISARM3 = 16'hFFC4;
    localparam logic [15:0] C_SEL_MODE3 = 16'hFF03;
    localparam logic [15:0] C_SEL_LOAD3 = 16'hFF0B;
    localparam logic [15:0] C_LOAD3 = 16'hFF44;
    localparam logic [15:0] V_MODE_1MHZ = 16'h8B25;
    localparam logic [15:0] V_MODE_EXT = 16'h8525;
    localparam logic [15:0] V_MODE_IDLE = 16'h0004;
    localparam logic [15:0] V_LOAD_SAFE = 16'h0003;
    localparam logic [15:0] V_ZERO = 16'h0000;
    localparam logic [2:0] TB_EXT = 3'h5;
    localparam logic [16:0] IVL_MIN = 17'h00002;
    localparam logic [16:0] IVL_MAX = 17'h10000;
    localparam logic [3:0] SETUP_LAST = 4'hC;
    localparam logic [3:0] RESET_LAST = 4'hE;
    localparam int unsigned FIFO_W = 16;
    localparam int unsigned FIFO_D = 16;
endpackage

// >>> ssq_sequencer.sv
// Host controller that programs, triggers and services scanned acquisition.
`timescale 1ns/100ps

// ==================================================
// Result FIFO
module ssq_fifo #(
    parameter int unsigned W = 16,
    parameter int unsigned D = 16
) (
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes follow the occupancy count.
    assign in_ready = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;
    assign out_data = mem_q[rp_q];

    // Storage array written at the write pointer.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ==================================================
// Sequencer
module ssq_sequencer
    import ssq_pkg::*;
(
    // Clock, reset and enable
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ce,
    // User commands and settings
    input wire logic cmd_setup,
    input wire logic cmd_trigger,
    input wire logic cmd_reset,
    input wire logic [2:0] cfg_timebase,
    input wire logic [16:0] cfg_scan_interval,
    input wire logic [16:0] cfg_sample_interval,
    input wire logic [4:0] cfg_seq_entries,
    input wire logic cfg_hw_trigger,
    input wire logic [16:0] cfg_result_count,
    // User status
    output logic busy,
    output logic armed,
    output logic done,
    output logic cfg_rejected,
    output logic overflow_seen,
    output logic overrun_seen,
    // Result stream
    output logic [15:0] res_data,
    output logic res_valid,
    input wire logic res_ready,
    // Device register interface
    output logic [7:0] dev_addr,
    output logic dev_wr,
    output logic dev_rd,
    output logic [15:0] dev_data_out,
    output logic dev_data_oe,
    input wire logic [15:0] dev_data_in,
    // Device trigger pin
    output logic external_start_trigger_n
);
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_SETUP = 9'h002,
        ST_ARMED = 9'h004,
        ST_TRIG = 9'h008,
        ST_STAT = 9'h010,
        ST_READ = 9'h020,
        ST_DONE = 9'h040,
        ST_HALT = 9'h080,
        ST_RESET = 9'h100
    } ssq_state_type;

    ssq_state_type st_q;
    logic [3:0] step_q;
    logic [15:0] mode_q;
    logic [15:0] ivl_q;
    logic hw_q;
    logic [16:0] target_q;
    logic [16:0] got_q;
    logic [7:0] trig_cnt_q;
    logic bus_act_q;
    logic bus_wr_q;
    logic [7:0] bus_cnt_q;
    logic [15:0] rd_s1_q;
    logic [15:0] rd_s2_q;
    logic rej_q;
    logic ovf_q;
    logic ovr_q;
    logic bus_go;
    logic bus_go_wr;
    logic [23:0] go_word;
    logic bus_done;
    logic fifo_in_ready;
    logic cfg_ok;
    logic [22:0] need_ticks;
    logic [15:0] mode_d;

    // Setup steps: counter programming, then clears and enables.
    function automatic logic [23:0] setup_step(input logic [3:0] i, input logic [15:0] m, input logic [15:0] v);
        logic [23:0] w;
        w = {A_CTR_CMD, C_SEL_MODE2};
        case (i)
            4'h0: w = {A_CTR_CMD, C_SEL_MODE2};
            4'h1: w = {A_CTR_DATA, m};
            4'h2: w = {A_CTR_CMD, C_SEL_LOAD2};
            4'h3: w = {A_CTR_DATA, V_LOAD_SAFE};
            4'h4: w = {A_CTR_CMD, C_LOAD2};
            4'h5: w = {A_CTR_CMD, C_STEP2};
            4'h6: w = {A_CTR_DATA, v};
            4'h7: w = {A_CTR_CMD, C_ARM2};
            4'h8: w = {A_CONV_CLEAR, V_ZERO};
            4'h9: w = {A_SCAN_PTR, V_ZERO};
            4'hA: w = {A_TMR_EDGE_CLR, V_ZERO};
            4'hB: w = {A_CMD1, 16'((1 << B_ACQ_EN) | (1 << B_SCAN_EN))};
            default: w = {A_CMD2, 16'(1 << B_SCAN2_EN)};
        endcase
        return w;
    endfunction

    // Reset steps: scan counter, sample counter, then clear errors.
    function automatic logic [23:0] reset_step(input logic [3:0] i);
        logic [23:0] w;
        w = {A_CTR_CMD, C_DISARM2};
        case (i)
            4'h0: w = {A_CTR_CMD, C_DISARM2};
            4'h1: w = {A_CTR_CMD, C_SEL_MODE2};
            4'h2: w = {A_CTR_DATA, V_MODE_IDLE};
            4'h3: w = {A_CTR_CMD, C_SEL_LOAD2};
            4'h4: w = {A_CTR_DATA, V_LOAD_SAFE};
            4'h5: w = {A_CTR_CMD, C_LOAD2};
            4'h6: w = {A_CTR_CMD, C_LOAD2};
            4'h7: w = {A_CTR_CMD, C_DISARM3};
            4'h8: w = {A_CTR_CMD, C_SEL_MODE3};
            4'h9: w = {A_CTR_DATA, V_MODE_IDLE};
            4'hA: w = {A_CTR_CMD, C_SEL_LOAD3};
            4'hB: w = {A_CTR_DATA, V_LOAD_SAFE};
            4'hC: w = {A_CTR_CMD, C_LOAD3};
            4'hD: w = {A_CTR_CMD, C_LOAD3};
            default: w = {A_CONV_CLEAR, V_ZERO};
        endcase
        return w;
    endfunction

    // Mode word from timebase index and settings check.
    always_comb begin
        mode_d = (cfg_timebase == TB_EXT) ? V_MODE_EXT : (V_MODE_1MHZ + {5'h00, cfg_timebase, 8'h00});
        need_ticks = {6'h00, cfg_sample_interval} * {18'h00000, cfg_seq_entries}
            + ((cfg_timebase == 3'h0) ? GUARD_TB1M : GUARD_SLOW);
        cfg_ok = (cfg_timebase <= TB_EXT)
            && (cfg_scan_interval >= IVL_MIN) && (cfg_scan_interval <= IVL_MAX)
            && ({6'h00, cfg_scan_interval} >= need_ticks)
            && ((cfg_timebase != 3'h0) || (cfg_sample_interval >= MIN_SAMPLE_TB1M))
            && (cfg_seq_entries != 5'h00) && (cfg_result_count != 17'h00000);
    end

    // Access request for the current state.
    always_comb begin
        bus_go = 1'b0;
        bus_go_wr = 1'b1;
        go_word = setup_step(step_q, mode_q, ivl_q);
        case (st_q)
            ST_SETUP: begin
                bus_go = !bus_act_q;
            end
            ST_RESET: begin
                bus_go = !bus_act_q;
                go_word = reset_step(step_q);
            end
            ST_TRIG: begin
                bus_go = !bus_act_q && !hw_q;
                go_word = {A_START, V_ZERO};
            end
            ST_STAT: begin
                bus_go = !bus_act_q;
                bus_go_wr = 1'b0;
                go_word = {A_STATUS, V_ZERO};
            end
            ST_READ: begin
                bus_go = !bus_act_q;
                bus_go_wr = 1'b0;
                go_word = {A_RESULT, V_ZERO};
            end
            default: begin
                bus_go = 1'b0;
            end
        endcase
    end

    assign bus_done = bus_act_q && (bus_cnt_q == 8'(STROBE_CYC - 1));

    // Device access engine: holds address, data and strobe for a fixed time.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_act_q <= 1'b0;
            bus_wr_q <= 1'b0;
            bus_cnt_q <= 8'h00;
            dev_addr <= 8'h00;
            dev_data_out <= 16'h0000;
        end else if (ce) begin
            if (bus_go) begin
                bus_act_q <= 1'b1;
                bus_wr_q <= bus_go_wr;
                bus_cnt_q <= 8'h00;
                dev_addr <= go_word[23:16];
                dev_data_out <= go_word[15:0];
            end else if (bus_done) begin
                bus_act_q <= 1'b0;
            end else if (bus_act_q) begin
                bus_cnt_q <= bus_cnt_q + 8'h01;
            end
        end
    end

    assign dev_wr = bus_act_q && bus_wr_q;
    assign dev_rd = bus_act_q && !bus_wr_q;
    assign dev_data_oe = bus_act_q && bus_wr_q;

    // Read data from the device passes two flip-flops.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_s1_q <= 16'h0000;
            rd_s2_q <= 16'h0000;
        end else if (ce) begin
            rd_s1_q <= dev_data_in;
            rd_s2_q <= rd_s1_q;
        end
    end

    // Main sequencing state machine.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            step_q <= 4'h0;
            mode_q <= 16'h0000;
            ivl_q <= 16'h0000;
            hw_q <= 1'b0;
            target_q <= 17'h00000;
            got_q <= 17'h00000;
            trig_cnt_q <= 8'h00;
            rej_q <= 1'b0;
            ovf_q <= 1'b0;
            ovr_q <= 1'b0;
        end else if (ce) begin
            case (st_q)
                ST_IDLE, ST_ARMED, ST_DONE, ST_HALT: begin
                    if (cmd_reset) begin
                        st_q <= ST_RESET;
                        step_q <= 4'h0;
                    end else if (cmd_setup && st_q != ST_HALT) begin
                        rej_q <= !cfg_ok;
                        if (cfg_ok) begin
                            st_q <= ST_SETUP;
                            step_q <= 4'h0;
                            mode_q <= mode_d;
                            ivl_q <= cfg_scan_interval[15:0];
                            hw_q <= cfg_hw_trigger;
                            target_q <= cfg_result_count;
                        end
                    end else if (cmd_trigger && (st_q == ST_ARMED || st_q == ST_DONE)) begin
                        st_q <= ST_TRIG;
                        got_q <= 17'h00000;
                        trig_cnt_q <= 8'h00;
                    end
                end
                ST_SETUP: begin
                    if (bus_done) begin
                        step_q <= step_q + 4'h1;
                        if (step_q == SETUP_LAST) begin
                            st_q <= ST_ARMED;
                            ovf_q <= 1'b0;
                            ovr_q <= 1'b0;
                        end
                    end
                end
                ST_RESET: begin
                    if (bus_done) begin
                        step_q <= step_q + 4'h1;
                        if (step_q == RESET_LAST) begin
                            st_q <= ST_IDLE;
                            ovf_q <= 1'b0;
                            ovr_q <= 1'b0;
                        end
                    end
                end
                ST_TRIG: begin
                    if (hw_q) begin
                        trig_cnt_q <= trig_cnt_q + 8'h01;
                        if (trig_cnt_q == 8'(TRIG_CYC - 1)) begin
                            st_q <= ST_STAT;
                        end
                    end else if (bus_done) begin
                        st_q <= ST_STAT;
                    end
                end
                ST_STAT: begin
                    if (bus_done) begin
                        if (rd_s2_q[B_OVERFLOW] || rd_s2_q[B_OVERRUN]) begin
                            st_q <= ST_HALT;
                            ovf_q <= rd_s2_q[B_OVERFLOW];
                            ovr_q <= rd_s2_q[B_OVERRUN];
                        end else if (rd_s2_q[B_AVAIL] && fifo_in_ready) begin
                            st_q <= ST_READ;
                        end
                    end
                end
                ST_READ: begin
                    if (bus_done) begin
                        got_q <= got_q + 17'h00001;
                        st_q <= (got_q + 17'h00001 == target_q) ? ST_DONE : ST_STAT;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Trigger pin pulses low while a hardware start is being given.
    assign external_start_trigger_n = !(st_q == ST_TRIG && hw_q);

    // Status views of the sequencer.
    assign busy = (st_q == ST_SETUP) || (st_q == ST_RESET) || (st_q == ST_TRIG)
        || (st_q == ST_STAT) || (st_q == ST_READ);
    assign armed = (st_q == ST_ARMED) || (st_q == ST_DONE);
    assign done = (st_q == ST_DONE);
    assign cfg_rejected = rej_q;
    assign overflow_seen = ovf_q;
    assign overrun_seen = ovr_q;

    // Results read from the device enter the FIFO.
    ssq_fifo #(
        .W(FIFO_W),
        .D(FIFO_D)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .in_valid(bus_done && (st_q == ST_READ)),
        .in_ready(fifo_in_ready),
        .in_data(rd_s2_q),
        .out_valid(res_valid),
        .out_ready(res_ready),
        .out_data(res_data)
    );
endmodule

// >>> ssq_sequencer_tb_top.sv
// Self-checking bench for the scanned acquisition host controller.
`timescale 1ns/100ps
module ssq_sequencer_tb_top import ssq_pkg::*; ;
    logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr_d = 1'b0, drain_en = 1'b1, ovr_req = 1'b0;
    logic cmd_setup = 1'b0, cmd_trigger = 1'b0, cmd_reset = 1'b0, cfg_hw_trigger = 1'b0, res_ready = 1'b0;
    logic [2:0] cfg_timebase = 3'h0;
    logic [16:0] cfg_scan_interval = 17'h10000, cfg_sample_interval = 17'h0002B, cfg_result_count = 17'h00005;
    logic [16:0] ivl;
    logic [4:0] cfg_seq_entries = 5'h03;
    logic busy, armed, done, cfg_rejected, overflow_seen, overrun_seen, res_valid, dev_wr, dev_rd, dev_data_oe;
    logic external_start_trigger_n;
    logic [15:0] res_data, dev_data_out, dev_data_in;
    logic [7:0] dev_addr;
    logic [23:0] got_wr[$], exp_wr[$];
    logic [15:0] exp_res[$];
    logic [15:0] rst_seq[14] = '{16'hFFC2, 16'hFF02, 16'h0004, 16'hFF0A, 16'h0003, 16'hFF42, 16'hFF42,
        16'hFFC4, 16'hFF03, 16'h0004, 16'hFF0B, 16'h0003, 16'hFF44, 16'hFF44};
    int mismatches = 0, check_count = 0, cyc = 0, ptr_m = 0, seq_m = 0;
    ssq_sequencer uut (.*);
    ssq_dev_model dev (.*, .sample_count(cfg_result_count));
    // Free-running clock.
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    // ==================================================
    // Checking tasks
    task automatic note(input logic [23:0] g, input logic [23:0] e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_wr(input logic [23:0] g, input logic [23:0] e); note(g, e); endtask
    task automatic cmp_res(input logic [15:0] g, input logic [15:0] e); note({8'h00, g}, {8'h00, e}); endtask
    task automatic cmp_flag(input logic g, input logic e); note({23'h0, g}, {23'h0, e}); endtask
    task automatic ew(input logic [7:0] a, input logic [15:0] d); exp_wr.push_back({a, d}); endtask
    // Checks logged writes against the expected list.
    task automatic chk_writes();
        cmp_wr(24'(got_wr.size()), 24'(exp_wr.size()));
        while (got_wr.size() != 0 && exp_wr.size() != 0) cmp_wr(got_wr.pop_front(), exp_wr.pop_front());
        got_wr.delete();
        exp_wr.delete();
    endtask
    // Expected writes of a setup: counter programming, clears, enables.
    task automatic exp_setup(input logic [2:0] t, input logic [16:0] n);
        ew(A_CTR_CMD, 16'hFF02);
        ew(A_CTR_DATA, t == 3'h5 ? 16'h8525 : 16'h8B25 + {5'h00, t, 8'h00});
        ew(A_CTR_CMD, 16'hFF0A);
        ew(A_CTR_DATA, 16'h0003);
        ew(A_CTR_CMD, 16'hFF42);
        ew(A_CTR_CMD, 16'hFFF2);
        ew(A_CTR_DATA, n[15:0]);
        ew(A_CTR_CMD, 16'hFF22);
        ew(A_CONV_CLEAR, 16'h0000);
        ew(A_SCAN_PTR, 16'h0000);
        ew(A_TMR_EDGE_CLR, 16'h0000);
        ew(A_CMD1, 16'h0003);
        ew(A_CMD2, 16'h0001);
        ptr_m = 0;
    endtask
    // Predicts results: channel pointer in the top nibble, conversion count below.
    task automatic conv(input int n, input int keep);
        for (int i = 0; i < n; i++) begin
            if (i < keep) exp_res.push_back({ptr_m[3:0], seq_m[11:0]});
            ptr_m = (ptr_m + 1) % 3;
            seq_m++;
        end
    endtask
    // Pulses one command (0 setup, 1 trigger, 2 reset) and waits for the controller to settle.
    task automatic issue(input int k);
        @(posedge ref_clk);
        cmd_setup <= k == 0;
        cmd_trigger <= k == 1;
        cmd_reset <= k == 2;
        @(posedge ref_clk);
        {cmd_setup, cmd_trigger, cmd_reset} <= 3'h0;
        repeat (2) @(posedge ref_clk);
        #1;
        for (int n = 0; n < 5000 && busy !== 1'b0; n++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    // Lets the stream drain until every predicted result is seen.
    task automatic drain();
        drain_en = 1'b1;
        for (int i = 0; i < 3000 && exp_res.size() != 0; i++) @(posedge ref_clk);
        cmp_res(16'(exp_res.size()), 16'h0000);
    endtask
    task automatic reset_chk();
        issue(2);
        foreach (rst_seq[i]) ew(rst_seq[i][15:8] == 8'hFF ? A_CTR_CMD : A_CTR_DATA, rst_seq[i]);
        ew(A_CONV_CLEAR, 16'h0000);
        chk_writes();
    endtask
    task automatic close_out();
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Logs device writes, checks streamed results and cuts a hang short.
    always @(posedge ref_clk) begin
        if (dev_wr && !wr_d) got_wr.push_back({dev_addr, dev_data_out});
        wr_d <= dev_wr;
        if (res_valid && res_ready) cmp_res(res_data, exp_res.pop_front());
        res_ready <= drain_en & 1'($urandom);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            close_out();
        end
    end
    // ==================================================
    // Scenarios
    initial begin
        void'($urandom(19));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        cfg_hw_trigger <= 1'b1;
        for (int t = 0; t <= 5; t++) begin
            ivl = t == 0 ? 17'h10000 : 17'h000C8 + 17'($urandom_range(0, 4000));
            cfg_timebase <= 3'(t);
            cfg_scan_interval <= ivl;
            issue(0);
            exp_setup(3'(t), ivl);
            chk_writes();
            cmp_flag(armed, 1'b1);
        end
        cfg_timebase <= 3'h6;
        issue(0);
        cmp_flag(cfg_rejected, 1'b1);
        chk_writes();
        cfg_timebase <= 3'h5;
        cfg_scan_interval <= 17'h00081;
        issue(0);
        cmp_flag(cfg_rejected, 1'b1);
        cfg_scan_interval <= ivl;
        conv(5, 5);
        issue(1);
        drain();
        chk_writes();
        cmp_flag(done, 1'b1);
        conv(5, 5);
        issue(1);
        drain();
        chk_writes();
        cmp_flag(done, 1'b1);
        cfg_hw_trigger <= 1'b0;
        cfg_result_count <= 17'h00028;
        drain_en = 1'b0;
        issue(0);
        exp_setup(3'h5, ivl);
        conv(32, 16);
        ew(A_START, 16'h0000);
        issue(1);
        cmp_flag(overflow_seen, 1'b1);
        cmp_flag(armed, 1'b0);
        drain();
        chk_writes();
        reset_chk();
        cmp_flag(overflow_seen, 1'b0);
        cfg_result_count <= 17'h00005;
        issue(0);
        exp_setup(3'h5, ivl);
        ovr_req <= 1'b1;
        ew(A_START, 16'h0000);
        issue(1);
        cmp_flag(overrun_seen, 1'b1);
        chk_writes();
        ovr_req <= 1'b0;
        reset_chk();
        cmp_flag(overrun_seen, 1'b0);
        close_out();
    end
endmodule
